// [src/bas_port_map.vh]
// constants of the bridge converter serial port: selects, widths, fields
`ifndef BAS_PORT_MAP_VH
`define BAS_PORT_MAP_VH

// register-select codes (comm write target shares code 0 with status read)
`define BAS_SEL_COMM     3'h0
`define BAS_SEL_STATUS   3'h0
`define BAS_SEL_DATA     3'h1
`define BAS_SEL_MODE     3'h2
`define BAS_SEL_FILTER   3'h3
`define BAS_SEL_DAC      3'h4
`define BAS_SEL_OFFSET   3'h5
`define BAS_SEL_GAIN     3'h6
`define BAS_SEL_NONE     3'h7

// register widths in bits
`define BAS_W_COMM       5'h08
`define BAS_W_STATUS     5'h08
`define BAS_W_DATA       5'h18
`define BAS_W_MODE       5'h10
`define BAS_W_FILTER     5'h18
`define BAS_W_DAC        5'h08
`define BAS_W_CAL        5'h18
`define BAS_W_NONE       5'h08

// communications register fields
`define BAS_COMM_RD_BIT  6
`define BAS_COMM_SEL_HI  2
`define BAS_COMM_SEL_LO  0

// mode register operating field and its codes
`define BAS_MODE_OP_HI   15
`define BAS_MODE_OP_LO   13
`define BAS_OP_IDLE      3'h0
`define BAS_OP_CONT      3'h1
`define BAS_OP_SINGLE    3'h2
`define BAS_OP_CAL_BIT   2

// reset values
`define BAS_RST_COMM     8'h00
`define BAS_RST_WORD     24'h000000

`endif

// [src/bas_regbank.v]
// register bank holding the software-written configuration words
module bas_regbank #(
    parameter DW = 24,
    parameter AW = 3
) (
    // clock and reset
    input  wire          mclk,
    input  wire          rst_n,
    // write port
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    // registered read port
    input  wire [AW-1:0] rdAddr,
    output reg  [DW-1:0] rdData
);
    reg     [DW-1:0] mem [0:(1<<AW)-1];
    integer          i;

    // no clock gating: contents stay as long as no write or reset arrives
    always @(posedge mclk) begin
        if (!rst_n) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem[i] <= {DW{1'b0}};
            end
            rdData <= {DW{1'b0}};
        end else begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule // bas_regbank

// [src/bas_port.v]
// serial port, data-ready and standby control of the bridge converter
`include "bas_port_map.vh"

module bas_port #(
    parameter DW = 24
) (
    // clock and reset
    input  wire          mclk,
    input  wire          rst_n,
    // pins
    input  wire          standbyN,
    input  wire          csN,
    input  wire          sclk,
    input  wire          sdin,
    output reg           sdout,
    output reg           sdoutOe,
    output reg           rdyN,
    // conversion and calibration engine
    input  wire          updStart,
    input  wire          updDone,
    input  wire [DW-1:0] resultWord,
    input  wire          calDone,
    output reg           calStart,
    output reg  [2:0]    modeOp,
    output reg           analogEn
);
    localparam ST_COMM = 3'b001;
    localparam ST_WR   = 3'b010;
    localparam ST_RD   = 3'b100;

    function [4:0] regWidth;
        input [2:0] sel;
        begin
            case (sel)
                `BAS_SEL_STATUS: regWidth = `BAS_W_STATUS;
                `BAS_SEL_DATA:   regWidth = `BAS_W_DATA;
                `BAS_SEL_MODE:   regWidth = `BAS_W_MODE;
                `BAS_SEL_FILTER: regWidth = `BAS_W_FILTER;
                `BAS_SEL_DAC:    regWidth = `BAS_W_DAC;
                `BAS_SEL_OFFSET: regWidth = `BAS_W_CAL;
                `BAS_SEL_GAIN:   regWidth = `BAS_W_CAL;
                default:         regWidth = `BAS_W_NONE;
            endcase
        end
    endfunction

    function inBank;
        input [2:0] sel;
        begin
            inBank = (sel >= `BAS_SEL_MODE) && (sel <= `BAS_SEL_GAIN);
        end
    endfunction

    // two-flop synchronisers; only stage [1] is read by logic
    reg [1:0]    sclkSync_ff;
    reg [1:0]    csSync_ff;
    reg [1:0]    dinSync_ff;
    reg [1:0]    stbySync_ff;
    reg          sclkPrev_ff;

    reg [2:0]    phase_ff;
    reg [4:0]    bitCnt_ff;
    reg [DW-1:0] inShift_ff;
    reg [DW-1:0] outShift_ff;
    reg [7:0]    comm_ff;
    reg [1:0]    loadPend_ff;
    reg [DW-1:0] data_ff;
    reg          calBusy_ff;
    reg          wrEn_ff;
    reg [2:0]    wrAddr_ff;
    reg [DW-1:0] wrData_ff;

    wire [DW-1:0] bankRd;
    wire          sclkS   = sclkSync_ff[1];
    wire          dinS    = dinSync_ff[1];
    wire          awake   = stbySync_ff[1];
    wire          selAct  = awake & ~csSync_ff[1];
    wire          sRise   = selAct & sclkS & ~sclkPrev_ff;
    wire          sFall   = selAct & ~sclkS & sclkPrev_ff;
    wire [2:0]    sel     = comm_ff[`BAS_COMM_SEL_HI:`BAS_COMM_SEL_LO];
    wire [4:0]    curW    = (phase_ff == ST_COMM) ? `BAS_W_COMM
                                                  : regWidth(sel);
    wire [4:0]    cntInc  = bitCnt_ff + 5'h01;
    wire [DW-1:0] inWord  = {inShift_ff[DW-2:0], dinS};
    wire          wordEnd = sRise & (cntInc == curW);
    wire          convOn  = (modeOp == `BAS_OP_CONT) |
                            (modeOp == `BAS_OP_SINGLE);
    wire [2:0]    newOp   = inWord[`BAS_MODE_OP_HI:`BAS_MODE_OP_LO];
    wire          modeWr  = wordEnd & (phase_ff == ST_WR) &
                            (sel == `BAS_SEL_MODE);
    wire          calGo   = modeWr & newOp[`BAS_OP_CAL_BIT];
    wire          readEnd = wordEnd & (phase_ff == ST_RD) &
                            (sel == `BAS_SEL_DATA);
    wire          evUpdS  = awake & convOn & updStart;
    wire          evUpdD  = awake & convOn & updDone;
    wire          evCalD  = awake & calBusy_ff & calDone;
    wire [7:0]    status  = {rdyN, calBusy_ff, awake, modeOp, 2'h0};

    reg  [DW-1:0] rdWord;
    reg  [DW-1:0] rdAligned;
    reg           nxt_rdyN;

    always @* begin
        case (sel)
            `BAS_SEL_STATUS: rdWord = {{(DW-8){1'b0}}, status};
            `BAS_SEL_DATA:   rdWord = data_ff;
            `BAS_SEL_NONE:   rdWord = {DW{1'b0}};
            default:         rdWord = bankRd;
        endcase
        // left-align so the word's top bit leaves first
        rdAligned = rdWord << (`BAS_W_DATA - regWidth(sel));
    end

    // later lines win: a new result beats a finished read in one cycle
    always @* begin
        nxt_rdyN = rdyN;
        if (readEnd | evUpdS) begin
            nxt_rdyN = 1'b1;
        end
        if (evUpdD | evCalD) begin
            nxt_rdyN = 1'b0;
        end
        if (awake & calGo) begin
            nxt_rdyN = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            sclkSync_ff <= 2'h3;
            csSync_ff   <= 2'h3;
            dinSync_ff  <= 2'h0;
            stbySync_ff <= 2'h0;
            sclkPrev_ff <= 1'b1;
        end else begin
            sclkSync_ff <= {sclkSync_ff[0], sclk};
            csSync_ff   <= {csSync_ff[0], csN};
            dinSync_ff  <= {dinSync_ff[0], sdin};
            stbySync_ff <= {stbySync_ff[0], standbyN};
            sclkPrev_ff <= sclkS;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            phase_ff    <= ST_COMM;
            bitCnt_ff   <= 5'h00;
            inShift_ff  <= `BAS_RST_WORD;
            outShift_ff <= `BAS_RST_WORD;
            comm_ff     <= `BAS_RST_COMM;
            loadPend_ff <= 2'h0;
            data_ff     <= `BAS_RST_WORD;
            calBusy_ff  <= 1'b0;
            wrEn_ff     <= 1'b0;
            wrAddr_ff   <= 3'h0;
            wrData_ff   <= `BAS_RST_WORD;
            sdout       <= 1'b0;
            sdoutOe     <= 1'b0;
            rdyN        <= 1'b1;
            calStart    <= 1'b0;
            modeOp      <= `BAS_OP_IDLE;
            analogEn    <= 1'b0;
        end else begin
            analogEn <= awake;
            wrEn_ff  <= 1'b0;
            calStart <= 1'b0;
            sdout    <= outShift_ff[DW-1];
            sdoutOe  <= selAct;
            rdyN     <= nxt_rdyN;
            // standby: nothing below moves, so all state is kept
            if (awake) begin
                loadPend_ff <= {loadPend_ff[0], 1'b0};
                if (loadPend_ff[1]) begin
                    outShift_ff <= rdAligned;
                // the first fall of a read keeps the top bit on the pin,
                // otherwise the host would never see it
                end else if (sFall && phase_ff == ST_RD &&
                             bitCnt_ff != 5'h00) begin
                    outShift_ff <= {outShift_ff[DW-2:0], 1'b0};
                end
                if (evUpdD) begin
                    data_ff <= resultWord;
                end
                if (evCalD) begin
                    calBusy_ff <= 1'b0;
                end
                // chip select high drops a partial word; tied low never does
                if (csSync_ff[1]) begin
                    bitCnt_ff <= 5'h00;
                end else if (sRise) begin
                    inShift_ff <= inWord;
                    bitCnt_ff  <= wordEnd ? 5'h00 : cntInc;
                end
                if (wordEnd) begin
                    case (phase_ff)
                        ST_COMM: begin
                            comm_ff <= inWord[7:0];
                            if (inWord[`BAS_COMM_RD_BIT]) begin
                                phase_ff    <= ST_RD;
                                loadPend_ff <= 2'h1;
                            end else begin
                                phase_ff <= ST_WR;
                            end
                        end
                        ST_WR: begin
                            phase_ff <= ST_COMM;
                            if (sel == `BAS_SEL_COMM) begin
                                comm_ff <= inWord[7:0];
                            end
                            if (inBank(sel)) begin
                                wrEn_ff   <= 1'b1;
                                wrAddr_ff <= sel;
                                wrData_ff <= inWord;
                            end
                            if (modeWr) begin
                                modeOp     <= newOp;
                                calBusy_ff <= newOp[`BAS_OP_CAL_BIT];
                                calStart   <= calGo;
                            end
                        end
                        ST_RD: begin
                            phase_ff <= ST_COMM;
                        end
                        default: begin
                            phase_ff <= ST_COMM;
                        end
                    endcase
                end
            end
        end
    end

    bas_regbank #(
        .DW (DW),
        .AW (3)
    ) u_bank (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .wrEn   (wrEn_ff),
        .wrAddr (wrAddr_ff),
        .wrData (wrData_ff),
        .rdAddr (sel),
        .rdData (bankRd)
    );
endmodule // bas_port

// [dv/bas_port_chk.sv]
// assertion checker for the serial port, data-ready and standby pins
module bas_port_chk (
    // clock and reset
    input wire        mclk,
    input wire        rst_n,
    // pins
    input wire        standbyN,
    input wire        csN,
    input wire        sclk,
    input wire        sdin,
    input wire        sdout,
    input wire        sdoutOe,
    input wire        rdyN,
    // engine
    input wire        updStart,
    input wire        updDone,
    input wire [23:0] resultWord,
    input wire        calDone,
    input wire        calStart,
    input wire [2:0]  modeOp,
    input wire        analogEn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reg  calBusy_ff;
    wire convOn = analogEn && (modeOp == 3'h1 || modeOp == 3'h2);
    // calibration in flight, so a stray finish pulse is not expected to act
    always @(posedge mclk) begin
        if (!rst_n) calBusy_ff <= 1'b0;
        else if (calStart) calBusy_ff <= 1'b1;
        else if (calDone && analogEn) calBusy_ff <= 1'b0;
    end
    chk_stby_off: assert property (!standbyN [*4] |-> !analogEn)
        else $error("analog enable stays on in standby");
    chk_stby_hold: assert property (!analogEn && $past(!analogEn)
        |=> $stable(modeOp) && $stable(rdyN))
        else $error("state changed during standby");
    chk_oe_cs: assert property (csN [*4] |-> !sdoutOe)
        else $error("data out driven while unselected");
    chk_oe_stby: assert property (!analogEn && $past(!analogEn)
        |-> !sdoutOe) else $error("data out driven in standby");
    chk_upd_done: assert property (updDone && convOn && !calStart
        |=> !rdyN) else $error("ready not low after new result");
    chk_upd_start: assert property (updStart && !updDone && convOn
        && !calStart |=> rdyN) else $error("ready not high during update");
    chk_rdy_fall: assert property ($fell(rdyN)
        |-> $past(updDone) || $past(calDone))
        else $error("ready fell without a cause");
    chk_cal_rdy: assert property (calStart |-> rdyN)
        else $error("ready not high at calibration start");
    chk_cal_pulse: assert property (calStart |=> !calStart)
        else $error("calibration start longer than one cycle");
    chk_cal_done: assert property (calDone && calBusy_ff
        && analogEn && !calStart |=> !rdyN)
        else $error("ready not low after calibration");
endmodule // bas_port_chk
bind bas_port bas_port_chk u_chk (.mclk(mclk), .rst_n(rst_n),
    .standbyN(standbyN), .csN(csN), .sclk(sclk), .sdin(sdin),
    .sdout(sdout), .sdoutOe(sdoutOe), .rdyN(rdyN), .updStart(updStart),
    .updDone(updDone), .resultWord(resultWord), .calDone(calDone),
    .calStart(calStart), .modeOp(modeOp), .analogEn(analogEn));

// [dv/bas_host.sv]
// host model: drives chip select, serial clock and data in, reads data out
module bas_host (
    // clock
    input  wire  mclk,
    // serial pins
    input  wire  sdout,
    output logic csN,
    output logic sclk,
    output logic sdin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        csN = 1'b1;
        sclk = 1'b1;
        sdin = 1'b1;
    end
    // half period of 4 mclk; data out read late so the sync lag is covered
    task automatic shift(input logic [23:0] wd, input int n,
                         output logic [23:0] rd);
        rd = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            sdin <= wd[i];
            repeat (4) @(negedge mclk);
            sclk <= 1'b1;
            repeat (4) @(negedge mclk);
            rd = {rd[22:0], sdout};
        end
    endtask
    // mode 0 select then release, 1 stay selected, 2 never selected
    task automatic frame(input logic [7:0] comm, input int n,
                         input logic [23:0] wd, input int mode,
                         output logic [23:0] rd);
        logic [23:0] junk;
        csN <= (mode == 2);
        repeat (4) @(negedge mclk);
        shift({16'h0000, comm}, 8, junk);
        shift(wd, n, rd);
        repeat (4) @(negedge mclk);
        csN <= (mode != 1);
        sdin <= ~sdin;
        repeat (8) @(negedge mclk);
    endtask
endmodule // bas_host

// [dv/test_bridge_adc_serial_port_ready.sv]
// testbench for the bridge converter serial port
module test_bridge_adc_serial_port_ready;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_n, standbyN, updStart, updDone, calDone;
    logic [23:0] resultWord, rd;
    wire         csN, sclk, sdin, sdout, sdoutOe, rdyN, calStart, analogEn;
    wire  [2:0]  modeOp;
    // released data out shows the inverse of its last level
    wire         sdoutPin = sdoutOe ? sdout : ~sdout;
    int          fail_count = 0;
    int          checked = 0;
    int          calSeen = 0;
    bas_port dut (.mclk(mclk), .rst_n(rst_n), .standbyN(standbyN),
        .csN(csN), .sclk(sclk), .sdin(sdin), .sdout(sdout),
        .sdoutOe(sdoutOe), .rdyN(rdyN), .updStart(updStart),
        .updDone(updDone), .resultWord(resultWord), .calDone(calDone),
        .calStart(calStart), .modeOp(modeOp), .analogEn(analogEn));
    bas_host host (.mclk(mclk), .sdout(sdoutPin), .csN(csN), .sclk(sclk),
        .sdin(sdin));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) if (calStart === 1'b1) calSeen++;
    task automatic cmp_bit(input string what, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic cmp_word(input string what, input logic [23:0] e,
                            input logic [23:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // k: 0 update start, 1 result ready, 2 calibration finished
    task automatic pulse(input int k, input logic [23:0] w);
        resultWord <= w;
        updStart <= (k == 0);
        updDone <= (k == 1);
        calDone <= (k == 2);
        @(negedge mclk);
        {updStart, updDone, calDone} <= 3'h0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic t_conv();
        host.frame(8'h02, 16, 24'h002000, 0, rd);
        cmp_word("modeOp", 24'h1, {21'h0, modeOp});
        pulse(1, 24'ha5c3e1);
        cmp_bit("rdyN new result", 1'b0, rdyN);
        host.frame(8'h41, 24, 24'h0, 0, rd);
        cmp_word("data read", 24'ha5c3e1, rd);
        cmp_bit("rdyN after read", 1'b1, rdyN);
        host.frame(8'h42, 16, 24'h0, 0, rd);
        cmp_word("mode read", 24'h002000, rd);
        host.frame(8'h40, 8, 24'h0, 0, rd);
        cmp_word("status read", 24'h0000a4, rd);
        $display("t_conv done");
    endtask
    task automatic t_unread();
        pulse(1, 24'h123456);
        pulse(0, 24'h0);
        cmp_bit("rdyN in update", 1'b1, rdyN);
        pulse(1, 24'h654321);
        cmp_bit("rdyN updated", 1'b0, rdyN);
        host.frame(8'h01, 24, 24'h0f0f0f, 0, rd);
        cmp_bit("rdyN before read", 1'b0, rdyN);
        host.frame(8'h41, 24, 24'h0, 0, rd);
        cmp_word("data kept", 24'h654321, rd);
        host.frame(8'h03, 24, 24'h5a5a5a, 0, rd);
        host.frame(8'h43, 24, 24'h0, 0, rd);
        cmp_word("filter read", 24'h5a5a5a, rd);
        $display("t_unread done");
    endtask
    task automatic t_cal();
        pulse(1, 24'h000001);
        host.frame(8'h02, 16, 24'h008000, 0, rd);
        cmp_word("modeOp cal", 24'h4, {21'h0, modeOp});
        cmp_bit("rdyN cal start", 1'b1, rdyN);
        cmp_word("calStart count", 24'h1, calSeen[23:0]);
        pulse(2, 24'h0);
        cmp_bit("rdyN cal done", 1'b0, rdyN);
        $display("t_cal done");
    endtask
    task automatic t_cs();
        host.frame(8'h02, 16, 24'h002000, 2, rd);
        cmp_word("modeOp unselected", 24'h4, {21'h0, modeOp});
        host.frame(8'h02, 16, 24'h004000, 1, rd);
        host.frame(8'h42, 16, 24'h0, 0, rd);
        cmp_word("three-wire read", 24'h004000, rd);
        $display("t_cs done");
    endtask
    task automatic t_stby();
        standbyN <= 1'b0;
        repeat (6) @(negedge mclk);
        cmp_bit("analogEn standby", 1'b0, analogEn);
        host.frame(8'h02, 16, 24'h002000, 0, rd);
        pulse(1, 24'h777777);
        cmp_word("modeOp standby", 24'h2, {21'h0, modeOp});
        standbyN <= 1'b1;
        repeat (6) @(negedge mclk);
        cmp_bit("analogEn awake", 1'b1, analogEn);
        host.frame(8'h42, 16, 24'h0, 0, rd);
        cmp_word("mode kept", 24'h004000, rd);
        $display("t_stby done");
    endtask
    task automatic close_out();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rst_n, updStart, updDone, calDone} = 4'h0;
        standbyN = 1'b1;
        resultWord = 24'h0;
        repeat (16) @(negedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(negedge mclk);
        cmp_bit("rdyN reset", 1'b1, rdyN);
        cmp_bit("analogEn up", 1'b1, analogEn);
        t_conv();
        t_unread();
        t_cal();
        t_cs();
        t_stby();
        close_out();
    end
    // the sequence needs well under 10000 cycles
    initial begin
        #3000000;
        $display("watchdog expired");
        fail_count++;
        close_out();
    end
endmodule // test_bridge_adc_serial_port_ready
